/* smr_mode_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "smr_regs.vh"
// Functional notes
// - Read of mode address 0 returns the capability/status register.
// - Status bit 0: 0 both refresh modes, 1 only modified refresh.
// - Status bit 1 reads 0, normal latency.
// - Two-bit self-test field reports the resistor pin test result.
// - Self-test result valid only after calibration start then latch plus delay.
// - Reset clears the self-test result.
// - On assembly error use factory drive strength and ignore calibration commands.
// - Status bit 7 shows command/address termination of this rank.
// - No byte-mode latency option is offered.
// - Burst/timing configuration register sits at mode address 1.
// - Burst field: 00 fixed 16, 01 fixed 32, 10 per-command choice.
// - Write preamble bit must be 1, two clock periods.
// - Read preamble bit: 0 static, 1 toggling.
// - Read postamble bit: 0 half period, 1 one and a half periods.
// - Per-command option: command operand picks 16 or 32 beats.
// - Write-recovery count delays internal precharge after auto-precharge write.
// - Config exists per set point; writes use write set-point copy, reads return zero.
// - Device operates from operating set-point copy only.
module smr_mode_regs #(
  parameter ZQLAT_CYC = `SMR_ZQLAT_CYC
) (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        link_clk,
  input  wire        mrw_valid,
  input  wire        mrr_valid,
  input  wire [5:0]  mode_address,
  input  wire [7:0]  mrw_data,
  input  wire        write_setpoint_sel,
  input  wire        operating_setpoint_sel,
  input  wire        only_modified_refresh,
  input  wire        ca_termination_pin,
  input  wire        zq_cal_start,
  input  wire        zq_cal_latch,
  input  wire [1:0]  zq_pin_sense,
  input  wire        rw_cmd,
  input  wire        rw_bl_operand,
  input  wire        ap_write_done,
  output reg  [7:0]  mrr_data,
  output reg         mrr_ack,
  output reg         factory_drive_strength,
  output reg         zq_cal_accept,
  output reg  [5:0]  burst_beats,
  output reg         write_preamble_2tck,
  output reg         read_preamble_toggle,
  output reg         read_postamble_long,
  output reg  [5:0]  write_recovery_count,
  output reg         precharge_start
);
  // ****************************************
  // Link clock sampling
  // ****************************************
  // Command strobes are taken on link clock rising edges, found by sampling
  reg  [2:0]  lclk_sync;
  reg         lclk_prev;
  wire        lclk_rise;
  always @(posedge sys_clk) begin
    if (!nrst) begin
      lclk_sync <= 3'h0;
      lclk_prev <= 1'b0;
    end else begin
      lclk_sync <= {lclk_sync[1:0], link_clk};
      if (lclk_sync[2] == lclk_sync[1])
        lclk_prev <= lclk_sync[2];
    end
  end
  assign lclk_rise = (lclk_sync[2] == lclk_sync[1]) && lclk_sync[2] && !lclk_prev;

  wire wr_cfg = lclk_rise && mrw_valid && (mode_address == `SMR_ADDR_CONFIG);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Straps and resistor test lines are asynchronous; a bit counts once the
  // last two stages agree, so a single metastable sample never lands
  wire [3:0]  pin_raw = {ca_termination_pin, only_modified_refresh, zq_pin_sense};
  wire [3:0]  pin_filt;
  genvar pb;
  generate
    for (pb = 0; pb < 4; pb = pb + 1) begin : g_pin
      reg [2:0] stage;
      reg       filt;
      always @(posedge sys_clk) begin
        if (!nrst) begin
          stage <= 3'h0;
          filt  <= 1'b0;
        end else begin
          stage <= {stage[1:0], pin_raw[pb]};
          if (stage[2] == stage[1])
            filt <= stage[2];
        end
      end
      assign pin_filt[pb] = filt;
    end
  endgenerate
  wire [1:0]  zq_sense_s = pin_filt[1:0];
  wire        refresh_s  = pin_filt[2];
  wire        ca_term_s  = pin_filt[3];

  // ****************************************
  // Self-test state
  // ****************************************
  localparam ZQ_IDLE    = 2'h0;
  localparam ZQ_STARTED = 2'h1;
  localparam ZQ_LATCH   = 2'h2;
  localparam ZQ_VALID   = 2'h3;
  reg  [1:0]  zq_state;
  reg  [15:0] zq_cnt;
  reg  [1:0]  resistor_selftest_result;
  always @(posedge sys_clk) begin
    if (!nrst) begin
      zq_state                 <= ZQ_IDLE;
      zq_cnt                   <= 16'h0000;
      resistor_selftest_result <= `SMR_ZQ_NOT_SUPP;
    end else begin
      case (zq_state)
        ZQ_IDLE: begin
          if (lclk_rise && zq_cal_start)
            zq_state <= ZQ_STARTED;
        end
        ZQ_STARTED: begin
          if (lclk_rise && zq_cal_latch) begin
            zq_state <= ZQ_LATCH;
            zq_cnt   <= 16'h0000;
          end
        end
        ZQ_LATCH: begin
          if (zq_cnt >= ZQLAT_CYC[15:0] - 16'h0001) begin
            zq_state                 <= ZQ_VALID;
            resistor_selftest_result <= zq_sense_s;
          end else begin
            zq_cnt <= zq_cnt + 16'h0001;
          end
        end
        ZQ_VALID: zq_state <= ZQ_VALID;
        default:  zq_state <= ZQ_IDLE;
      endcase
    end
  end

  // Assembly error: factory trim and calibration refused until reset
  wire asm_err = (resistor_selftest_result == `SMR_ZQ_LOW_FLOAT) ||
                 (resistor_selftest_result == `SMR_ZQ_SHORT_HIGH);

  // ****************************************
  // Config copies per set point
  // ****************************************
  reg  [7:0]  cfg_sp [0:1];
  genvar sp;
  generate
    for (sp = 0; sp < 2; sp = sp + 1) begin : g_sp
      always @(posedge sys_clk) begin
        if (!nrst)
          cfg_sp[sp] <= `SMR_CF_RESET;
        else if (wr_cfg && (write_setpoint_sel == sp))
          cfg_sp[sp] <= mrw_data;
      end
    end
  endgenerate

  wire [7:0] cfg_op = cfg_sp[operating_setpoint_sel];
  wire [5:0] wr_cyc;
  smr_wr_decode u_wr (
    .code   (cfg_op[`SMR_CF_WR_HI:`SMR_CF_WR_LO]),
    .cycles (wr_cyc)
  );

  // Status byte; latency bit and byte-mode fixed zero
  wire [7:0] status;
  assign status = {ca_term_s, 2'h0, resistor_selftest_result, 1'b0, 1'b0, refresh_s};

  // ****************************************
  // Mode register read
  // ****************************************
  // The config register is write-only, so reads of it return zero
  always @(posedge sys_clk) begin
    if (!nrst) begin
      mrr_data <= 8'h00;
      mrr_ack  <= 1'b0;
    end else begin
      mrr_ack <= lclk_rise && mrr_valid;
      if (lclk_rise && mrr_valid) begin
        if (mode_address == `SMR_ADDR_STATUS)
          mrr_data <= status;
        else
          mrr_data <= 8'h00;
      end
    end
  end

  // ****************************************
  // Operating controls
  // ****************************************
  reg [5:0] rec_cnt;
  reg       rec_busy;
  always @(posedge sys_clk) begin
    if (!nrst) begin
      factory_drive_strength <= 1'b0;
      zq_cal_accept          <= 1'b0;
      burst_beats            <= `SMR_BEATS_16;
      write_preamble_2tck    <= 1'b1;
      read_preamble_toggle   <= 1'b0;
      read_postamble_long    <= 1'b0;
      write_recovery_count   <= `SMR_REC_C0;
      precharge_start        <= 1'b0;
      rec_cnt                <= 6'h00;
      rec_busy               <= 1'b0;
    end else begin
      factory_drive_strength <= asm_err;
      zq_cal_accept          <= lclk_rise && (zq_cal_start || zq_cal_latch) && !asm_err;
      write_preamble_2tck    <= cfg_op[`SMR_CF_WPRE];
      read_preamble_toggle   <= cfg_op[`SMR_CF_RPRE];
      read_postamble_long    <= cfg_op[`SMR_CF_RD_POST];
      write_recovery_count   <= wr_cyc;
      if (lclk_rise && rw_cmd) begin
        case (cfg_op[`SMR_CF_BURST_HI:`SMR_CF_BURST_LO])
          `SMR_BURST_FIX16:   burst_beats <= `SMR_BEATS_16;
          `SMR_BURST_FIX32:   burst_beats <= `SMR_BEATS_32;
          `SMR_BURST_PER_CMD: burst_beats <= rw_bl_operand ? `SMR_BEATS_32 : `SMR_BEATS_16;
          default:            burst_beats <= `SMR_BEATS_16;
        endcase
      end
      precharge_start <= 1'b0;
      if (lclk_rise && ap_write_done) begin
        rec_busy <= 1'b1;
        rec_cnt  <= 6'h01;
      end else if (rec_busy) begin
        if (rec_cnt >= wr_cyc) begin
          rec_busy        <= 1'b0;
          precharge_start <= 1'b1;
        end else begin
          rec_cnt <= rec_cnt + 6'h01;
        end
      end
    end
  end
endmodule // smr_mode_regs
`default_nettype wire

/* smr_regs.vh */
`ifndef SMR_REGS_VH
`define SMR_REGS_VH
// ****************************************
// Mode addresses
// ****************************************
`define SMR_ADDR_W          6
`define SMR_ADDR_STATUS     6'h00
`define SMR_ADDR_CONFIG     6'h01
// ****************************************
// Status register fields
// ****************************************
`define SMR_ST_REFRESH      0
`define SMR_ST_LATENCY      1
`define SMR_ST_ZQ_LO        3
`define SMR_ST_ZQ_HI        4
`define SMR_ST_CA_TERM      7
`define SMR_ZQ_NOT_SUPP     2'h0
`define SMR_ZQ_LOW_FLOAT    2'h1
`define SMR_ZQ_SHORT_HIGH   2'h2
`define SMR_ZQ_PASS         2'h3
// ****************************************
// Config register fields
// ****************************************
`define SMR_CF_BURST_LO     0
`define SMR_CF_BURST_HI     1
`define SMR_CF_WPRE         2
`define SMR_CF_RPRE         3
`define SMR_CF_WR_LO        4
`define SMR_CF_WR_HI        6
`define SMR_CF_RD_POST      7
`define SMR_CF_RESET        8'h04
`define SMR_BURST_FIX16     2'h0
`define SMR_BURST_FIX32     2'h1
`define SMR_BURST_PER_CMD   2'h2
`define SMR_BEATS_16        6'h10
`define SMR_BEATS_32        6'h20
// ****************************************
// Write-recovery counts per code
// ****************************************
`define SMR_REC_C0          6'h06
`define SMR_REC_C1          6'h0A
`define SMR_REC_C2          6'h10
`define SMR_REC_C3          6'h14
`define SMR_REC_C4          6'h18
`define SMR_REC_C5          6'h1E
`define SMR_REC_C6          6'h22
`define SMR_REC_C7          6'h28
// ****************************************
// Timing
// ****************************************
`define SMR_CLK_MHZ         200
`define SMR_ZQLAT_NS        30
`define SMR_ZQLAT_CYC       ((`SMR_ZQLAT_NS * `SMR_CLK_MHZ + 999) / 1000)
`define SMR_WR_W            6
`endif

/* smr_wr_decode.v */
`timescale 1ns/1ps
`default_nettype none
`include "smr_regs.vh"
module smr_wr_decode (
  input  wire [2:0]            code,
  output reg  [`SMR_WR_W-1:0] cycles
);
  always @* begin
    case (code)
      3'h0:    cycles = `SMR_REC_C0;
      3'h1:    cycles = `SMR_REC_C1;
      3'h2:    cycles = `SMR_REC_C2;
      3'h3:    cycles = `SMR_REC_C3;
      3'h4:    cycles = `SMR_REC_C4;
      3'h5:    cycles = `SMR_REC_C5;
      3'h6:    cycles = `SMR_REC_C6;
      default: cycles = `SMR_REC_C7;
    endcase
  end
endmodule // smr_wr_decode
`default_nettype wire

/* smr_mode_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module smr_mode_regs_monitor (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic [5:0] mode_address,
  input wire logic       only_modified_refresh,
  input wire logic       ca_termination_pin,
  input wire logic [7:0] mrr_data,
  input wire logic       mrr_ack,
  input wire logic       factory_drive_strength,
  input wire logic       zq_cal_accept,
  input wire logic [5:0] burst_beats,
  input wire logic       write_preamble_2tck,
  input wire logic [5:0] write_recovery_count
);
  // ****
  // Checks
  // ****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Address is held by the controller for the whole command
  wire st = mrr_ack && mode_address == 6'h00;
  property p_ack; mrr_ack |=> !mrr_ack; endproperty
  a_ack: assert property (p_ack) else $error("read ack too long");
  property p_ref; st |-> mrr_data[0] == only_modified_refresh; endproperty
  a_ref: assert property (p_ref) else $error("refresh bit wrong");
  property p_lat; st |-> mrr_data[1] == 1'b0; endproperty
  a_lat: assert property (p_lat) else $error("latency bit set");
  property p_ca; st |-> mrr_data[7] == ca_termination_pin; endproperty
  a_ca: assert property (p_ca) else $error("termination bit wrong");
  property p_wo; mrr_ack && mode_address != 6'h00 |-> mrr_data == 8'h00; endproperty
  a_wo: assert property (p_wo) else $error("nonzero read data");
  property p_zq; factory_drive_strength |-> !zq_cal_accept; endproperty
  a_zq: assert property (p_zq) else $error("calibration accepted");
  property p_fac; !$fell(factory_drive_strength); endproperty
  a_fac: assert property (p_fac) else $error("factory trim dropped");
  property p_wpre; write_preamble_2tck; endproperty
  a_wpre: assert property (p_wpre) else $error("write preamble off");
  property p_burst; burst_beats == 6'h10 || burst_beats == 6'h20; endproperty
  a_burst: assert property (p_burst) else $error("bad burst beats");
  property p_wr; write_recovery_count inside {6'h06, 6'h0A, 6'h10, 6'h14, 6'h18, 6'h1E, 6'h22, 6'h28}; endproperty
  a_wr: assert property (p_wr) else $error("bad recovery count");
endmodule // smr_mode_regs_monitor
bind smr_mode_regs smr_mode_regs_monitor i_mon (.sys_clk, .nrst, .mode_address, .only_modified_refresh,
  .ca_termination_pin, .mrr_data, .mrr_ack, .factory_drive_strength, .zq_cal_accept, .burst_beats,
  .write_preamble_2tck, .write_recovery_count);
`default_nettype wire

/* smr_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module smr_ctrl_model (
  input  wire logic       sys_clk,
  output var  logic       link_clk,
  output var  logic       mrw_valid,
  output var  logic       mrr_valid,
  output var  logic [5:0] mode_address,
  output var  logic [7:0] mrw_data
);
  // ****
  // One command per link clock pulse
  // ****
  initial begin
    link_clk = 1'b0;
    mrw_valid = 1'b0;
    mrr_valid = 1'b0;
    mode_address = 6'h00;
    mrw_data = 8'h00;
  end
  task automatic cmd(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    mrw_valid <= w;
    mrr_valid <= r;
    mode_address <= a;
    mrw_data <= d;
    repeat (8) @(posedge sys_clk);
    link_clk <= 1'b1;
    repeat (8) @(posedge sys_clk);
    link_clk <= 1'b0;
    repeat (2) @(posedge sys_clk);
    mrw_valid <= 1'b0;
    mrr_valid <= 1'b0;
    // Released lines flip so a stale value cannot pass
    mode_address <= ~a;
    mrw_data <= ~d;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule // smr_ctrl_model
`default_nettype wire

/* smr_mode_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module smr_mode_regs_tb_top;
  logic        sys_clk = 1'b0, nrst = 1'b0, link_clk, mrw_valid, mrr_valid, mrr_ack;
  logic        write_setpoint_sel, operating_setpoint_sel, only_modified_refresh, ca_termination_pin;
  logic        zq_cal_start, zq_cal_latch, factory_drive_strength, zq_cal_accept;
  logic        write_preamble_2tck, read_preamble_toggle, read_postamble_long;
  logic [1:0]  zq_pin_sense;
  logic [5:0]  mode_address, burst_beats, write_recovery_count;
  logic [7:0]  mrw_data, mrr_data, d;
  logic        rw_cmd, rw_bl_operand, ap_write_done, precharge_start, lk_q = 1'b0;
  logic [31:0] seed = 32'h5CF5, r;
  int          mismatches = 0, num_checks = 0, e;
  int          cyc = 0, t_lk = 0, t_pc = 0, n_acc = 0, acc0;
  int          cfg [2];
  int          rec_tab [8] = '{6, 10, 16, 20, 24, 30, 34, 40};
  // Link rise to sampled precharge: three sampler stages plus the registered strobe
  localparam int SYNC_LAT = 4;
  always #2.5 sys_clk = ~sys_clk;
  smr_mode_regs #(.ZQLAT_CYC(6)) i_smr_mode_regs (.sys_clk, .nrst, .link_clk, .mrw_valid, .mrr_valid,
    .mode_address, .mrw_data, .write_setpoint_sel, .operating_setpoint_sel, .only_modified_refresh,
    .ca_termination_pin, .zq_cal_start, .zq_cal_latch, .zq_pin_sense, .rw_cmd, .rw_bl_operand,
    .ap_write_done, .mrr_data, .mrr_ack, .factory_drive_strength, .zq_cal_accept, .burst_beats,
    .write_preamble_2tck, .read_preamble_toggle, .read_postamble_long, .write_recovery_count,
    .precharge_start);
  smr_ctrl_model i_smr_ctrl_model (.sys_clk, .link_clk, .mrw_valid, .mrr_valid, .mode_address, .mrw_data);
  // Cycle stamps of link rise and precharge pulse; calibration acceptances counted
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    lk_q <= link_clk;
    if (link_clk === 1'b1 && lk_q === 1'b0) t_lk <= cyc;
    if (precharge_start === 1'b1) t_pc <= cyc;
    if (zq_cal_accept === 1'b1) n_acc <= n_acc + 1;
  end
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rst();
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    cfg = '{4, 4};
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] x);
    i_smr_ctrl_model.cmd(1'b0, 1'b1, a, 8'h00);
    chk(mrr_data, x);
  endtask
  // Calibration start, then latch; the latch delay ends well before the return
  task automatic zq(input logic [1:0] p);
    zq_pin_sense <= p;
    zq_cal_start <= 1'b1;
    i_smr_ctrl_model.cmd(1'b0, 1'b0, 6'h3F, 8'h00);
    zq_cal_start <= 1'b0;
    zq_cal_latch <= 1'b1;
    i_smr_ctrl_model.cmd(1'b0, 1'b0, 6'h3F, 8'h00);
    zq_cal_latch <= 1'b0;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    {write_setpoint_sel, operating_setpoint_sel, only_modified_refresh, ca_termination_pin} = 4'h0;
    {zq_cal_start, zq_cal_latch, zq_pin_sense} = 4'h0;
    {rw_cmd, rw_bl_operand, ap_write_done} = 3'h0;
    rst();
    for (int i = 0; i < 4; i++) begin
      {ca_termination_pin, only_modified_refresh} <= i[1:0];
      rd(6'h00, {i[1], 6'h00, i[0]});
    end
    for (int p = 1; p < 4; p++) begin
      rst();
      rd(6'h00, 8'h81);
      acc0 = n_acc;
      zq(p[1:0]);
      rd(6'h00, {3'h4, p[1:0], 3'h1});
      chk(factory_drive_strength, p != 3);
      chk(n_acc - acc0, 2);
      zq(2'h3);
      rd(6'h00, {3'h4, p[1:0], 3'h1});
      chk(n_acc - acc0, (p == 3) ? 4 : 2);
    end
    rst();
    for (int i = 0; i < 16; i++) begin
      r = xs();
      // Burst code 11 is reserved, so it folds onto the per-command option
      d = {r[0], i[2:0], r[1], 1'b1, (r[8:7] == 2'h3) ? 2'h2 : r[8:7]};
      write_setpoint_sel <= r[3];
      operating_setpoint_sel <= r[4];
      i_smr_ctrl_model.cmd(1'b1, 1'b0, 6'h01, d);
      cfg[r[3]] = d;
      e = cfg[r[4]];
      rw_cmd <= 1'b1;
      rw_bl_operand <= r[5];
      ap_write_done <= 1'b1;
      i_smr_ctrl_model.cmd(1'b0, 1'b0, 6'h3F, 8'h00);
      {rw_cmd, ap_write_done} <= 2'h0;
      repeat (40) @(posedge sys_clk);
      chk({burst_beats, write_preamble_2tck, read_preamble_toggle, read_postamble_long, write_recovery_count},
          {(e[1:0] == 1 || (e[1:0] == 2 && r[5])) ? 6'h20 : 6'h10, e[2], e[3], e[7],
           rec_tab[e[6:4]][5:0]});
      chk(t_pc - t_lk, rec_tab[e[6:4]] + SYNC_LAT);
    end
    rd(6'h01, 8'h00);
    rd(6'h2A, 8'h00);
    conclude();
  end
  initial begin
    #60000;
    mismatches++;
    conclude();
  end
endmodule // smr_mode_regs_tb_top
`default_nettype wire
